// ===== logic/block_move_sequencer.sv
module block_move_sequencer
    import block_move_pkg::*;
#(
    parameter int CYCLE_W = 24
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic start,
    input wire move_kind_t kind,
    input wire move_regs_t regsIn,
    input wire logic [7:0] ccrIn,
    output mem_req_t memReq,
    input wire logic memReady,
    input wire logic rdValid,
    input wire logic [DATA_W-1:0] rdData,
    output move_regs_t regsOut,
    output logic [7:0] ccrOut,
    output logic busy,
    output logic done,
    output logic [CYCLE_W-1:0] stateCount
);
    if (CYCLE_W < 20) begin
        $error("CYCLE_W too small for a full 16-bit count");
    end

    localparam int CREDIT_W = $clog2(FIFO_DEPTH) + 1;

    typedef enum logic [1:0] {
        IDLE,
        READ,
        WRITE,
        FINISH
    } phase_t;

    typedef struct packed {
        phase_t phase;
        move_regs_t regs;
        logic [ADDR_W-1:0] rdAddr;
        logic [15:0] rdLeft;
        logic [7:0] ccr;
        logic done;
        logic [CYCLE_W-1:0] cycles;
        move_kind_t kind;
        logic [CREDIT_W-1:0] credit;
        logic [CYCLE_W-1:0] budget;
    } seq_state_t;

    seq_state_t st;
    seq_state_t next_st;
    logic fifoInReady;
    logic fifoOutValid;
    logic [DATA_W-1:0] fifoOutData;
    logic fifoPop;
    logic issueRead;
    logic readTaken;
    logic [15:0] startCount;

    function automatic logic [15:0] eff_count(move_kind_t k,
                                              logic [15:0] c);
        // The byte variant sees only the low byte of the count.
        return (k == block_move_byte_count) ? (c & BYTE_MASK) : c;
    endfunction

    // ===================================================================
    // Read-ahead buffer between source reads and destination writes.
    // ===================================================================
    byte_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rst(rst),
        .inValid(rdValid),
        .inReady(fifoInReady),
        .inData(rdData),
        .outValid(fifoOutValid),
        .outReady(fifoPop),
        .outData(fifoOutData)
    );

    // Reads in flight plus bytes held never exceed the buffer, so no
    // answer can arrive while it is full.
    assign issueRead = (st.phase == READ) && (st.rdLeft != COUNT_ZERO)
                       && (st.credit != CREDIT_W'(FIFO_DEPTH))
                       && fifoInReady && !rdValid;
    assign readTaken = issueRead && memReady;
    assign startCount = eff_count(kind, regsIn.count);
    assign fifoPop = (st.phase == READ) && fifoOutValid && !issueRead
                     && memReady;

    // ===================================================================
    // Sequencer.
    // ===================================================================
    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        if (st.phase != IDLE) begin
            next_st.cycles = st.cycles + 1'b1;
        end
        unique case (st.phase)
            IDLE: begin
                if (start) begin
                    // The byte variant leaves the upper count byte alone.
                    next_st.regs = regsIn;
                    next_st.kind = kind;
                    next_st.rdAddr = regsIn.src;
                    next_st.rdLeft = startCount;
                    next_st.ccr = ccrIn;
                    next_st.cycles = CYCLE_W'(1);
                    next_st.credit = '0;
                    next_st.budget = CYCLE_W'(BASE_STATES)
                        + CYCLE_W'(STATES_PER_BYTE) * CYCLE_W'(startCount);
                    // Zero count moves nothing and only waits out the base.
                    if (startCount == COUNT_ZERO) begin
                        next_st.phase = WRITE;
                    end else begin
                        next_st.phase = READ;
                    end
                end
            end
            READ: begin
                if (readTaken) begin
                    next_st.rdAddr = st.rdAddr + STEP_ONE;
                    next_st.rdLeft = st.rdLeft - STEP_ONE;
                    next_st.credit = st.credit + 1'b1;
                end
                if (fifoPop) begin
                    // One byte moved: both pointers up, count down.
                    next_st.regs.src = st.regs.src + STEP_ONE;
                    next_st.regs.dst = st.regs.dst + STEP_ONE;
                    next_st.regs.count = st.regs.count - STEP_ONE;
                    next_st.credit = st.credit - 1'b1;
                    if (eff_count(st.kind, st.regs.count) == STEP_ONE) begin
                        next_st.phase = WRITE;
                    end
                end
            end
            WRITE: begin
                // Pad to the base-plus-per-byte budget; a slow bus only adds.
                if (st.cycles >= st.budget - CYCLE_W'(1)) begin
                    next_st.phase = FINISH;
                end
            end
            FINISH: begin
                next_st.phase = IDLE;
                next_st.done = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    always_comb begin
        memReq = '0;
        if (issueRead) begin
            memReq.rdReq = 1'b1;
            memReq.addr = st.rdAddr;
        end else if (fifoPop) begin
            memReq.wrReq = 1'b1;
            memReq.addr = st.regs.dst;
            memReq.wdata = fifoOutData;
        end
    end

    assign regsOut = st.regs;
    assign ccrOut = st.ccr;
    assign busy = (st.phase != IDLE);
    assign done = st.done;
    // Documented state count for the run just started or finished.
    assign stateCount = st.budget;
endmodule

// ===== logic/block_move_pkg.sv
package block_move_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 8;
    localparam int BASE_STATES = 8;
    localparam int STATES_PER_BYTE = 8;
    localparam logic [15:0] COUNT_ZERO = 16'h0000;
    localparam logic [15:0] STEP_ONE = 16'h0001;
    localparam logic [15:0] BYTE_MASK = 16'h00ff;

    typedef enum logic {
        block_move_byte_count,
        block_move_word_count
    } move_kind_t;

    typedef struct packed {
        logic [15:0] count;
        logic [ADDR_W-1:0] src;
        logic [ADDR_W-1:0] dst;
    } move_regs_t;

    typedef struct packed {
        logic rdReq;
        logic wrReq;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } mem_req_t;
endpackage

// ===== logic/byte_fifo.sv
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
        $error("byte_fifo depth must be a power of two");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] rp;
        logic [AW-1:0] wp;
        logic [AW:0] level;
    } fifo_state_t;

    fifo_state_t st;
    fifo_state_t next_st;
    logic push;
    logic pop;

    assign inReady = (st.level != DEPTH[AW:0]);
    assign outValid = (st.level != '0);
    assign outData = st.mem[st.rp];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wp] = inData;
            next_st.wp = st.wp + 1'b1;
        end
        if (pop) begin
            next_st.rp = st.rp + 1'b1;
        end
        if (push && !pop) begin
            next_st.level = st.level + 1'b1;
        end else if (pop && !push) begin
            next_st.level = st.level - 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

// ===== testbench/block_move_checker.sv
module block_move_checker
    import block_move_pkg::*;
#(
    parameter int CYCLE_W = 24
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic start,
    input wire move_kind_t kind,
    input wire move_regs_t regsIn,
    input wire logic [7:0] ccrIn,
    input wire mem_req_t memReq,
    input wire logic memReady,
    input wire logic rdValid,
    input wire logic [DATA_W-1:0] rdData,
    input wire move_regs_t regsOut,
    input wire logic [7:0] ccrOut,
    input wire logic busy,
    input wire logic done,
    input wire logic [CYCLE_W-1:0] stateCount
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic [15:0] n;
    logic go;
    logic [CYCLE_W-1:0] runCycles;
    assign n = kind ? regsIn.count : regsIn.count & BYTE_MASK;
    assign go = start && !busy;
    // Counts the start cycle and the busy cycles of the run that was started last.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            runCycles <= '0;
        end else if (go) begin
            runCycles <= CYCLE_W'(1);
        end else if (busy) begin
            runCycles <= runCycles + CYCLE_W'(1);
        end
    end
    property p_noop;
        go && n == COUNT_ZERO |-> (!memReq.rdReq && !memReq.wrReq)[*8]
            ##1 !done ##1 done;
    endproperty
    a_noop: assert property (p_noop) else $error("zero count moved");
    property p_run;
        go && n != COUNT_ZERO |=> busy;
    endproperty
    a_run: assert property (p_run) else $error("copy not started");
    property p_idle;
        !busy |-> !memReq.rdReq && !memReq.wrReq;
    endproperty
    a_idle: assert property (p_idle) else $error("bus used idle");
    property p_time;
        go |=> stateCount == BASE_STATES + STATES_PER_BYTE * $past(n);
    endproperty
    a_time: assert property (p_time) else $error("bad state figure");
    property p_pad;
        done |-> runCycles > stateCount;
    endproperty
    a_pad: assert property (p_pad) else $error("run too short");
    property p_ccr;
        go |=> ccrOut == $past(ccrIn);
    endproperty
    a_ccr: assert property (p_ccr) else $error("flags changed");
    property p_step;
        memReq.wrReq && memReady |=> regsOut.dst == $past(regsOut.dst)
            + 16'h0001;
    endproperty
    a_step: assert property (p_step) else $error("pointer not stepped");
    c_zero: cover property (go && n == COUNT_ZERO);
    c_wr: cover property (memReq.wrReq && memReady);
    c_done: cover property (done);
endmodule

bind block_move_sequencer block_move_checker #(.CYCLE_W(CYCLE_W)) i_chk (.*);

// ===== testbench/mem_model.sv
module mem_model
    import block_move_pkg::*;
(
    input wire logic clk_sys,
    input wire mem_req_t memReq,
    output logic memReady,
    output logic rdValid,
    output logic [DATA_W-1:0] rdData
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] q[$];
    function automatic logic [7:0] f(logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h3c;
    endfunction
    initial begin
        memReady = 1'b0;
        rdValid = 1'b0;
        rdData = 8'h00;
    end
    always @(posedge clk_sys)
        if (memReq.rdReq && memReady) q.push_back(memReq.addr);
    // Random stalls stand for slower memory stretching execution.
    always @(negedge clk_sys) begin
        memReady <= $urandom_range(3) != 0;
        rdValid <= 1'b0;
        rdData <= ~rdData;
        if (q.size() != 0 && $urandom_range(1) != 0) begin
            rdValid <= 1'b1;
            rdData <= f(q.pop_front());
        end
    end
endmodule

// ===== testbench/cpu_block_move_sequencer_tb.sv
module cpu_block_move_sequencer_tb;
    import block_move_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
    $display("unexpected %s exp %0h got %0h", nm, e, g); end end
    logic clk_sys, rst, start, memReady, rdValid, busy, done;
    move_kind_t kind;
    move_regs_t regsIn, regsOut;
    logic [7:0] ccrIn, ccrOut, rdData;
    mem_req_t memReq;
    logic [23:0] stateCount;
    int n_fail = 0;
    int checks = 0;
    int nWr;
    logic [15:0] s0, d0;
    block_move_sequencer i_dut (.*);
    mem_model i_mem (.clk_sys(clk_sys), .memReq(memReq),
        .memReady(memReady), .rdValid(rdValid), .rdData(rdData));
    always #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
        if (!rst && memReq.wrReq && memReady) begin
            `CHK("wrAddr", d0 + nWr[15:0], memReq.addr)
            `CHK("wrData", i_mem.f(s0 + nWr[15:0]), memReq.wdata)
            nWr++;
        end
    task automatic end_of_test();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic run(move_kind_t k, logic [15:0] c, s, d);
        logic [15:0] n, e;
        logic [7:0] cc;
        int t;
        n = k == block_move_byte_count ? c & BYTE_MASK : c;
        e = k == block_move_byte_count ? c & ~BYTE_MASK : COUNT_ZERO;
        cc = 8'($urandom);
        s0 = s;
        d0 = d;
        nWr = 0;
        kind = k;
        regsIn = '{c, s, d};
        ccrIn = cc;
        start = 1'b1;
        @(negedge clk_sys);
        t = 0;
        // A second start while busy must be ignored.
        while (done !== 1'b1 && t < 9000) begin
            start = t == 2;
            regsIn.src = ~s;
            @(negedge clk_sys);
            t++;
        end
        if (t == 9000) begin
            n_fail++;
            end_of_test();
        end
        `CHK("time", 1'b1, t >= BASE_STATES + STATES_PER_BYTE * n)
        `CHK("nWr", n, nWr[15:0])
        `CHK("src", s + n, regsOut.src)
        `CHK("dst", d + n, regsOut.dst)
        `CHK("cnt", e, regsOut.count)
        `CHK("ccr", cc, ccrOut)
        $display("test end kind %0d n %0d", k, n);
    endtask
    initial begin
        clk_sys = 1'b0;
        rst = 1'b1;
        start = 1'b0;
        kind = block_move_byte_count;
        regsIn = '0;
        ccrIn = 8'h00;
        void'($urandom(74));
        repeat (16) @(negedge clk_sys);
        rst = 1'b0;
        @(negedge clk_sys);
        run(block_move_byte_count, 16'h0300, 16'h1000, 16'h2000);
        run(block_move_word_count, 16'h0000, 16'h1000, 16'h2000);
        run(block_move_word_count, 16'h0100, 16'hfff0, 16'h4000);
        run(block_move_byte_count, 16'h01ff, 16'h0123, 16'h8000);
        for (int i = 0; i < 8; i++) begin
            run(move_kind_t'(1'($urandom_range(1))),
                16'($urandom_range(24)), 16'($urandom), 16'($urandom));
        end
        end_of_test();
    end
endmodule
